// >>> design/qass_pkg.sv
package qass_pkg;

   // widths of the converter and its control word
   localparam int CODE_BITS      = 10;
   localparam int CHAN_BITS      = 2;
   localparam int CTRL_BITS      = 8;
   localparam int POS_BITS       = 5;
   localparam int CODE_STEPS     = 1024;   // one step is supply over this
   localparam int FIFO_DEPTH     = 8;

   // positions of edges inside one sixteen-clock group, counted from 1
   localparam logic [4:0] POS_IDLE        = 5'h00;
   localparam logic [4:0] POS_FIRST       = 5'h01;
   localparam logic [4:0] POS_SECOND      = 5'h02;
   localparam logic [4:0] TRACK_LAST_FALL = 5'h03;
   localparam logic [4:0] HOLD_FIRST_FALL = 5'h04;
   localparam logic [4:0] MSB_CLOCK       = 5'h05;
   localparam logic [4:0] LSB_CLOCK       = 5'h0e;
   localparam logic [4:0] CTRL_LAST_RISE  = 5'h08;
   localparam logic [4:0] GROUP_LAST      = 5'h10;

   // channel field of the next_channel_select_word
   localparam int CHAN_FIELD_LO  = 3;
   localparam int CHAN_FIELD_HI  = 4;

   // values after reset
   localparam logic [1:0] DEFAULT_CHAN = 2'h0;
   localparam logic [9:0] CODE_RESET   = 10'h000;
   localparam logic [7:0] CTRL_RESET   = 8'h00;

   // converter phase seen from the link side
   typedef enum logic [1:0] {
      PH_TRACK,
      PH_HOLD,
      PH_SLEEP
   } qass_phase_t;

   // one finished conversion handed to the core side
   typedef struct packed {
      logic [CHAN_BITS-1:0] chan;
      logic [CODE_BITS-1:0] code;
   } qass_result_t;

endpackage

// >>> design/qass_sequencer.sv
`timescale 1ns/1ps

// small synchronous fifo for finished conversions
module qass_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_reg;
   logic [AW-1:0]    rdPtr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // wrap a pointer at the configured depth, not at a power of two
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // honest full and empty from one occupancy count
   assign inReady  = (count_reg != (AW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData  = mem[rdPtr_reg];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // storage has no reset, it is qualified by the count
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= bump(wrPtr_reg);
         end
         if (pop) begin
            rdPtr_reg <= bump(rdPtr_reg);
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

module qass_sequencer import qass_pkg::*; #(
   parameter int FIFO_WORDS = FIFO_DEPTH
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 frameSelN,
   input  wire logic                 serialClk,
   input  wire logic                 serialIn,
   input  wire logic [CODE_BITS-1:0] analogInputOne,
   input  wire logic [CODE_BITS-1:0] analogInputTwo,
   input  wire logic [CODE_BITS-1:0] analogInputThree,
   input  wire logic [CODE_BITS-1:0] analogInputFour,
   output logic                      serialOut,
   output logic                      serialOutOe,
   output logic                      holdActive,
   output logic                      powerDown,
   output qass_result_t              resultData,
   output logic                      resultValid,
   input  wire logic                 resultReady,
   output logic                      frameActive,
   output logic                      overrunFlag,
   input  wire logic                 overrunClear
);

   // link side state
   logic                 frameRstN;
   logic                 riseSeen_reg;
   logic [POS_BITS-1:0]  risePos_reg;
   logic [POS_BITS-1:0]  risePos_next;
   logic [CTRL_BITS-1:0] ctrlShift_reg;
   logic [CTRL_BITS-1:0] ctrlShift_next;
   logic [CHAN_BITS-1:0] chanSel_reg;
   logic [POS_BITS-1:0]  fallPos_reg;
   logic [POS_BITS-1:0]  fallPos_next;
   qass_phase_t          phase_reg;
   logic [CODE_BITS-1:0] heldCode_reg;
   logic                 serialOut_reg;
   logic                 holdActive_reg;
   qass_result_t         xferData_reg;
   logic                 xferTog_reg;
   logic                 dropTog_reg;
   logic                 ackMeta_reg;
   logic                 ackSync_reg;
   logic [POS_BITS-1:0]  bitIndex;

   // core side state
   logic                 xferMeta_reg;
   logic                 xferSync_reg;
   logic                 xferSeen_reg;
   logic                 dropMeta_reg;
   logic                 dropSync_reg;
   logic                 dropSeen_reg;
   logic                 frameMeta_reg;
   logic                 frameActive_reg;
   logic                 overrun_reg;
   logic                 newWord;
   logic                 fifoInReady;

   // pick the held code for a channel, only the two low field bits count
   function automatic logic [CODE_BITS-1:0] pickCode(input logic [CHAN_BITS-1:0] ch,
                                                      input logic [CODE_BITS-1:0] a0,
                                                      input logic [CODE_BITS-1:0] a1,
                                                      input logic [CODE_BITS-1:0] a2,
                                                      input logic [CODE_BITS-1:0] a3);
      case (ch)
         2'h0:    return a0;
         2'h1:    return a1;
         2'h2:    return a2;
         default: return a3;
      endcase
   endfunction

   // frame select high gates the internal clock off: position, shift, phase and output state reset; the channel does not
   assign frameRstN = rst_n & ~frameSelN;

   // output enable follows frame select directly, as on the pin
   assign serialOutOe = ~frameSelN;
   assign serialOut   = serialOut_reg;
   assign holdActive  = holdActive_reg;
   // asleep outside a frame and during the last clock of a group
   assign powerDown   = frameSelN | (phase_reg == PH_SLEEP);

   // rising-edge position inside the current group, wraps for the next group
   always_comb begin
      if (risePos_reg == GROUP_LAST || risePos_reg == POS_IDLE) begin
         risePos_next = POS_FIRST;
      end else begin
         risePos_next = risePos_reg + 1'b1;
      end
      ctrlShift_next = {ctrlShift_reg[CTRL_BITS-2:0], serialIn};
   end

   // rises sample the control word on the first eight edges of each group
   always_ff @(posedge serialClk or negedge frameRstN) begin
      if (!frameRstN) begin
         riseSeen_reg  <= 1'b0;
         risePos_reg   <= POS_IDLE;
         ctrlShift_reg <= CTRL_RESET;
      end else begin
         riseSeen_reg <= 1'b1;
         risePos_reg  <= risePos_next;
         if (risePos_next <= CTRL_LAST_RISE) begin
            ctrlShift_reg <= ctrlShift_next;
         end
      end
   end

   // channel for the next hold survives between frames; input one after reset
   always_ff @(posedge serialClk or negedge rst_n) begin
      if (!rst_n) begin
         chanSel_reg <= DEFAULT_CHAN;
      end else if (!frameSelN && risePos_next == CTRL_LAST_RISE) begin
         // bits 7..5 and 2..0 are dropped here on purpose
         chanSel_reg <= ctrlShift_next[CHAN_FIELD_HI:CHAN_FIELD_LO];
      end
   end

   // falling-edge position; a rise before the first fall means the clock
   // rested low, so the select fall already stood in for fall one
   always_comb begin
      if (fallPos_reg == POS_IDLE) begin
         fallPos_next = riseSeen_reg ? POS_SECOND : POS_FIRST;
      end else if (fallPos_reg == GROUP_LAST) begin
         fallPos_next = POS_FIRST;
      end else begin
         fallPos_next = fallPos_reg + 1'b1;
      end
      bitIndex = LSB_CLOCK - fallPos_next;
   end

   // phase, held sample and output bit all move on falling edges
   always_ff @(negedge serialClk or negedge frameRstN) begin
      if (!frameRstN) begin
         fallPos_reg    <= POS_IDLE;
         phase_reg      <= PH_TRACK;
         heldCode_reg   <= CODE_RESET;
         serialOut_reg  <= 1'b0;
         holdActive_reg <= 1'b0;
      end else begin
         fallPos_reg <= fallPos_next;
         case (1'b1)
            (fallPos_next <= TRACK_LAST_FALL): begin
               phase_reg      <= PH_TRACK;
               holdActive_reg <= 1'b0;
            end
            (fallPos_next < GROUP_LAST): begin
               phase_reg      <= PH_HOLD;
               holdActive_reg <= 1'b1;
            end
            default: begin
               phase_reg      <= PH_SLEEP;
               holdActive_reg <= 1'b1;
            end
         endcase
         if (fallPos_next == HOLD_FIRST_FALL) begin
            // the channel latched in the previous conversion is used now
            heldCode_reg <= pickCode(chanSel_reg, analogInputOne, analogInputTwo,
                                     analogInputThree, analogInputFour);
         end
         // zeros before and after the ten result bits, msb on clock five
         if (fallPos_next >= MSB_CLOCK && fallPos_next <= LSB_CLOCK) begin
            serialOut_reg <= heldCode_reg[bitIndex[3:0]];
         end else begin
            serialOut_reg <= 1'b0;
         end
      end
   end

   // acknowledge from the core side, two flops on the link clock
   always_ff @(negedge serialClk or negedge rst_n) begin
      if (!rst_n) begin
         ackMeta_reg <= 1'b0;
         ackSync_reg <= 1'b0;
      end else begin
         ackMeta_reg <= xferSeen_reg;
         ackSync_reg <= ackMeta_reg;
      end
   end

   // post each held sample to the core; the link clock cannot be stalled,
   // so a sample that finds the last one unacknowledged is dropped and flagged
   always_ff @(negedge serialClk or negedge rst_n) begin
      if (!rst_n) begin
         xferData_reg <= '0;
         xferTog_reg  <= 1'b0;
         dropTog_reg  <= 1'b0;
      end else if (!frameSelN && fallPos_next == HOLD_FIRST_FALL) begin
         if (xferTog_reg == ackSync_reg) begin
            xferData_reg.chan <= chanSel_reg;
            xferData_reg.code <= pickCode(chanSel_reg, analogInputOne, analogInputTwo,
                                          analogInputThree, analogInputFour);
            xferTog_reg       <= ~xferTog_reg;
         end else begin
            dropTog_reg <= ~dropTog_reg;
         end
      end
   end

   // toggles and frame level into the core clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xferMeta_reg    <= 1'b0;
         xferSync_reg    <= 1'b0;
         dropMeta_reg    <= 1'b0;
         dropSync_reg    <= 1'b0;
         frameMeta_reg   <= 1'b0;
         frameActive_reg <= 1'b0;
      end else begin
         xferMeta_reg    <= xferTog_reg;
         xferSync_reg    <= xferMeta_reg;
         dropMeta_reg    <= dropTog_reg;
         dropSync_reg    <= dropMeta_reg;
         frameMeta_reg   <= ~frameSelN;
         frameActive_reg <= frameMeta_reg;
      end
   end

   assign frameActive = frameActive_reg;
   assign overrunFlag = overrun_reg;

   // a new word waits here while the fifo is full, which holds the ack back
   assign newWord = (xferSync_reg != xferSeen_reg);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xferSeen_reg <= 1'b0;
      end else if (newWord && fifoInReady) begin
         xferSeen_reg <= xferSync_reg;
      end
   end

   // sticky overrun; a drop arriving with the clear still sets it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dropSeen_reg <= 1'b0;
         overrun_reg  <= 1'b0;
      end else begin
         dropSeen_reg <= dropSync_reg;
         if (dropSync_reg != dropSeen_reg) begin
            overrun_reg <= 1'b1;
         end else if (overrunClear) begin
            overrun_reg <= 1'b0;
         end
      end
   end

   // xferData is stable while its toggle is unacknowledged, so it is read here
   qass_fifo #(
      .WIDTH ($bits(qass_result_t)),
      .DEPTH (FIFO_WORDS)
   ) resultFifo (
      .clk      (core_clk),
      .rst_n    (rst_n),
      .inValid  (newWord),
      .inData   (xferData_reg),
      .inReady  (fifoInReady),
      .outValid (resultValid),
      .outData  (resultData),
      .outReady (resultReady)
   );

endmodule

// >>> test/qass_host_model.sv
`timescale 1ns/1ps
// host serial port: frames, clock, control word, result capture
module qass_host_model (
   output logic      frameSelN,
   output logic      serialClk,
   output logic      serialIn,
   input  wire logic serialOut,
   input  wire logic serialOutOe
);
   logic idleLvl;   // where the clock parks between frames

   initial begin
      frameSelN = 1'b1;
      serialClk = 1'b1;
      serialIn  = 1'b0;
      idleLvl   = 1'b1;
   end

   // park the clock, then open; generous setup around the select edge
   task automatic open_frame(input logic lvl);
      idleLvl   = lvl;
      serialClk = lvl;
      #100;
      frameSelN = 1'b0;
      #100;
   endtask

   // one sixteen-clock conversion: drive on falls, capture on rises
   task automatic convert(input logic [7:0] word, output logic [15:0] got);
      for (int i = 0; i < 16; i++) begin
         serialClk = 1'b0;
         serialIn  = (i < 8) ? word[7-i] : ~serialIn;
         #62.5; // logic has no minimum period, so the bench runs fast
         serialClk = 1'b1;
         got[15-i] = serialOutOe ? serialOut : 1'bx;
         #62.5;
      end
   endtask

   // whole groups only; the released data line never shows a stale bit
   task automatic close_frame();
      serialClk = idleLvl;
      #100;
      frameSelN = 1'b1;
      serialIn  = ~serialIn;
      #100;
   endtask
endmodule

// >>> test/qass_sequencer_asserts.sv
`timescale 1ns/1ps
// pin and stream checks for the converter sequencer
module qass_sequencer_asserts import qass_pkg::*; (
   input wire logic         core_clk,
   input wire logic         rst_n,
   input wire logic         frameSelN,
   input wire logic         serialClk,
   input wire logic         serialOut,
   input wire logic         serialOutOe,
   input wire logic         holdActive,
   input wire logic         powerDown,
   input wire qass_result_t resultData,
   input wire logic         resultValid,
   input wire logic         resultReady
);
   logic [3:0] riseCnt_reg;   // rises already seen in this group

   // select high clears it, the same gating the device applies
   always_ff @(posedge serialClk or posedge frameSelN) begin
      if (frameSelN)
         riseCnt_reg <= 4'h0;
      else
         riseCnt_reg <= riseCnt_reg + 4'h1;
   end

   // track span, then the first part of hold
   sequence trackSeq;
      !holdActive [*3];
   endsequence
   sequence holdSeq;
      holdActive [*8];
   endsequence

   chk_oe_select: assert property (
      @(posedge core_clk) disable iff (!rst_n) serialOutOe == !frameSelN)
      else $error("output enable differs from frame select");
   chk_pd_outside: assert property (
      @(posedge core_clk) disable iff (!rst_n) frameSelN |-> powerDown)
      else $error("powered up outside a frame");
   chk_pd_inside: assert property (
      @(posedge serialClk) disable iff (frameSelN) riseCnt_reg != 4'hf |-> !powerDown)
      else $error("powered down inside a conversion");
   chk_out_on_fall: assert property (
      @(posedge core_clk) disable iff (!rst_n) !frameSelN && $changed(serialOut) |-> !serialClk)
      else $error("serial output moved while clock high");
   chk_result_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      resultValid && !resultReady |=> resultValid && $stable(resultData))
      else $error("result dropped before taken");
   chk_track_hold: assert property (
      @(posedge serialClk) disable iff (frameSelN) riseCnt_reg == 4'h0 |-> trackSeq ##1 holdSeq)
      else $error("track and hold phases misplaced");
   chk_hold_tail: assert property (
      @(posedge serialClk) disable iff (frameSelN) riseCnt_reg == 4'hb |-> holdActive [*4])
      else $error("hold ended early");
   chk_lead_zeros: assert property (
      @(posedge serialClk) disable iff (frameSelN) riseCnt_reg == 4'h0 |-> !serialOut [*4])
      else $error("leading bits not zero");
   chk_tail_zeros: assert property (
      @(posedge serialClk) disable iff (frameSelN) riseCnt_reg == 4'he |-> !serialOut [*2])
      else $error("trailing bits not zero");
   chk_sleep_last: assert property (
      @(posedge serialClk) disable iff (frameSelN)
      riseCnt_reg == 4'hf |-> powerDown ##1 !powerDown [*8])
      else $error("sleep clock wrong");
endmodule

bind qass_sequencer qass_sequencer_asserts chk (
   .core_clk(core_clk), .rst_n(rst_n), .frameSelN(frameSelN), .serialClk(serialClk),
   .serialOut(serialOut), .serialOutOe(serialOutOe), .holdActive(holdActive),
   .powerDown(powerDown), .resultData(resultData), .resultValid(resultValid),
   .resultReady(resultReady)
);

// >>> test/tb_qass_sequencer.sv
`timescale 1ns/1ps
// bench for the four-input converter sequencer
module tb_qass_sequencer import qass_pkg::*; ;
   typedef struct packed { logic [7:0] word; logic [1:0] chan; } qass_row_t;

   logic         core_clk;
   logic         rst_n;
   logic         resultReady;
   logic         overrunClear;
   logic [9:0]   ana [4];
   wire          frameSelN, serialClk, serialIn, serialOut, serialOutOe;
   wire          holdActive, powerDown, resultValid, frameActive, overrunFlag;
   qass_result_t resultData;
   qass_result_t expQ [$];
   qass_result_t gotQ [$];
   logic [1:0]   curChan = 2'h0;
   int           fails = 0;
   int           comparisons = 0;
   int           cycles = 0;
   // ignored bits set both ways, every channel code
   qass_row_t    rows [5] = '{'{8'hc7, 2'h0}, '{8'h28, 2'h1}, '{8'h30, 2'h2},
                              '{8'h3f, 2'h3}, '{8'h08, 2'h1}};

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   qass_sequencer uut (.core_clk(core_clk), .rst_n(rst_n), .frameSelN(frameSelN),
      .serialClk(serialClk), .serialIn(serialIn), .analogInputOne(ana[0]),
      .analogInputTwo(ana[1]), .analogInputThree(ana[2]), .analogInputFour(ana[3]),
      .serialOut(serialOut), .serialOutOe(serialOutOe), .holdActive(holdActive),
      .powerDown(powerDown), .resultData(resultData), .resultValid(resultValid),
      .resultReady(resultReady), .frameActive(frameActive), .overrunFlag(overrunFlag),
      .overrunClear(overrunClear));

   qass_host_model host (.frameSelN(frameSelN), .serialClk(serialClk),
      .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe));

   task automatic report_and_stop();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         fails++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   // one frame of n conversions, rows taken in turn
   task automatic run_frame(input logic lvl, input int first, input int n);
      logic [15:0] got;
      logic [9:0]  code;
      host.open_frame(lvl);
      // status pins follow the select; the core copy lags two core clocks
      chk(frameActive === 1'b1 && !powerDown && serialOutOe === 1'b1, "open");
      for (int i = 0; i < n; i++) begin
         code = ana[curChan];
         host.convert(rows[(first + i) % 5].word, got);
         chk(got === {4'h0, code, 2'h0}, "serial word");
         expQ.push_back({curChan, code});
         curChan = rows[(first + i) % 5].chan;
      end
      host.close_frame();
      chk(frameActive === 1'b0 && powerDown === 1'b1 && !serialOutOe, "closed");
   endtask

   // compare the first n words delivered on the core side
   task automatic check_results(input int n);
      for (int i = 0; i < 300 && gotQ.size() < n; i++)
         @(posedge core_clk);
      chk(gotQ.size() >= n, "result count");
      for (int i = 0; i < n && gotQ.size() > 0; i++)
         chk(gotQ.pop_front() === expQ.pop_front(), "result word");
      expQ.delete();
      gotQ.delete();
   endtask

   // collect every accepted result
   always @(posedge core_clk)
      if (rst_n === 1'b1 && resultValid === 1'b1 && resultReady === 1'b1)
         gotQ.push_back(resultData);

   // hang guard, well above the expected run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin
      rst_n = 1'b0;
      resultReady = 1'b1;
      overrunClear = 1'b0;
      ana = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001};
      repeat (5) @(posedge core_clk);
      #1 rst_n = 1'b1;
      chk(resultValid === 1'b0 && overrunFlag === 1'b0 && frameActive === 1'b0, "reset");
      chk(powerDown === 1'b1 && serialOutOe === 1'b0, "idle pins");
      run_frame(1'b0, 0, 5);
      check_results(5);
      run_frame(1'b1, 0, 2);
      check_results(2);
      // stalled stream: buffer fills, the crossing waits, a sample is lost
      @(posedge core_clk);
      #1 resultReady = 1'b0;
      run_frame(1'b1, 1, 10);
      chk(overrunFlag === 1'b1 && resultValid === 1'b1, "overrun flag");
      @(posedge core_clk);
      #1 resultReady = 1'b1;
      // eight words buffered plus one held at the crossing; only the tenth is lost
      check_results(9);
      @(posedge core_clk);
      #1 overrunClear = 1'b1;
      @(posedge core_clk);
      #1 overrunClear = 1'b0;
      @(posedge core_clk);
      #1 chk(overrunFlag === 1'b0, "overrun clear");
      // second reset: channel falls back to input one
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 rst_n = 1'b1;
      curChan = 2'h0;
      run_frame(1'b0, 2, 1);
      check_results(1);
      report_and_stop();
   end
endmodule
